// ---- rtl/cpr_pkg.sv ----
/*
 * Shared constants and types of the operand cache read path.
 * Assumes one core clock, 64-bit memory beats and 32-byte cache lines.
 */
`default_nettype none

package cpr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int NUM_WAYS = 2;      // Ways per set
    localparam int NUM_SETS = 256;    // Sets, one per index value
    localparam int BEATS = 4;         // Quad-words per line
    localparam int IDX_HI = 12;       // Line index, top bit of virtual address
    localparam int IDX_LO = 5;        // Line index, low bit of virtual address
    localparam int TAG_HI = 28;       // Tag, top bit of physical address
    localparam int TAG_LO = 10;       // Tag, low bit of physical address
    localparam int QW_HI = 4;         // Quad-word select, top bit
    localparam int QW_LO = 3;         // Quad-word select, low bit
    localparam int TAG_W = TAG_HI - TAG_LO + 1;
    localparam int IDX_W = IDX_HI - IDX_LO + 1;
    localparam int PA_W = 29;         // Physical address width
    localparam int VA_W = 32;         // Virtual address width
    localparam int QW_W = 64;         // One quad-word, 8 bytes

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and last beat number
    localparam logic VALID_RST = 1'b0;
    localparam logic DIRTY_RST = 1'b0;
    localparam logic LRU_RST = 1'b0;
    localparam logic [1:0] LAST_BEAT = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [VA_W-1:0] vaddr;       // Virtual address of the load
        logic [PA_W-1:0] paddr;       // Translated physical address
        logic [1:0] size;             // 0:1 byte 1:2 bytes 2:4 bytes 3:8 bytes
        logic cacheable;              // Target region may be cached
    } cpr_req_t;

    typedef struct packed {
        logic [PA_W-1:0] addr;        // Quad-word aligned start address
        logic burst;                  // 1: four-beat wrapping line read
    } cpr_rd_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LOOKUP, ST_SAVE, ST_FILL_REQ, ST_FILL, ST_WB, ST_BYP_REQ, ST_BYP_WAIT
    } cpr_state_t;

endpackage

`default_nettype wire

// ---- rtl/cpr_way_match.sv ----
/*
 * Tag compare of one cache way.
 * Assumes stored tag and valid flag are already read for the indexed set.
 */
`default_nettype none

module cpr_way_match #(
    parameter int TAG_W = 19
) (
    // Stored side
    input wire logic [TAG_W-1:0] stored_tag_i,
    input wire logic valid_i,
    // Lookup side
    input wire logic [TAG_W-1:0] lookup_tag_i,
    output logic hit_o
);

    // A hit needs both an equal tag and a live line
    assign hit_o = valid_i && (stored_tag_i == lookup_tag_i);

endmodule

`default_nettype wire

// ---- rtl/cpr_read_path.sv ----
/*
 * Read path of a two-way set-associative operand cache with write-back buffer.
 * Assumes the core holds one load at a time and the memory bus returns line
 * beats in wraparound order; the store path marks lines dirty via a port.
 */
// What this block does
// - Lookup only when enabled and region cacheable
// - Index by virtual bits 12:5, read all ways
// - Hit needs physical tag 28:10 and valid
// - Hit returns sized data, makes way newest
// - Clean victim refilled without write-back
// - Dirty victim goes through eviction path
// - Refill wraps from missed quad-word
// - Missed data returned on first beat
// - Core proceeds while line still fills
// - Fill end: tag, valid, clean, newest
// - Dirty victim copied to buffer first
// - Buffer written out after refill completes
`default_nettype none

module cpr_read_path
    import cpr_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    // Core load port
    input wire logic REQ_VALID_I,
    output logic REQ_READY_O,
    input wire cpr_req_t REQ_I,
    input wire logic CACHE_ENABLE_I,
    output logic RSP_VALID_O,
    output logic [QW_W-1:0] RSP_DATA_O,
    // Dirty marking from the store path
    input wire logic DIRTY_SET_I,
    input wire logic [IDX_W-1:0] DIRTY_SET_INDEX_I,
    input wire logic DIRTY_SET_WAY_I,
    // Memory read port
    output logic MEM_RD_REQ_O,
    output cpr_rd_cmd_t MEM_RD_CMD_O,
    input wire logic MEM_RD_ACK_I,
    input wire logic MEM_RD_VALID_I,
    input wire logic [QW_W-1:0] MEM_RD_DATA_I,
    // Memory write port
    output logic MEM_WR_VALID_O,
    output logic [PA_W-1:0] MEM_WR_ADDR_O,
    output logic [QW_W-1:0] MEM_WR_DATA_O,
    output logic MEM_WR_LAST_O,
    input wire logic MEM_WR_READY_I
);

    ////////////////////////////////////////////////////////////////////////////
    // State and storage
    cpr_state_t state_q, state_d;                 // Control sequence
    cpr_req_t req_q, req_d;                       // Load in progress
    logic en_q, en_d;                             // Enable sampled with the load
    logic way_q, way_d;                           // Hit or victim way
    logic [1:0] beat_q, beat_d;                   // Beat counter
    logic rsp_valid_q, rsp_valid_d;               // Response strobe
    logic [QW_W-1:0] rsp_data_q, rsp_data_d;      // Response data
    logic wbpend_q, wbpend_d;                     // Buffer holds a dirty line
    logic [PA_W-1:0] wb_addr_q, wb_addr_d;        // Buffered line address
    logic [QW_W-1:0] wb_data_q [BEATS];           // Buffered line data
    logic [QW_W-1:0] wb_data_d [BEATS];
    cpr_rd_cmd_t rd_cmd_q, rd_cmd_d;              // Read command to memory
    logic [TAG_W-1:0] tag_mem [NUM_WAYS][NUM_SETS];
    logic [QW_W-1:0] data_mem [NUM_WAYS][NUM_SETS][BEATS];
    logic [NUM_SETS-1:0] valid_q [NUM_WAYS];
    logic [NUM_SETS-1:0] dirty_q [NUM_WAYS];
    logic [NUM_SETS-1:0] lru_q;                   // Way to replace next

    ////////////////////////////////////////////////////////////////////////////
    // Lookup
    logic [IDX_W-1:0] idx;                        // Set of the current load
    logic [TAG_W-1:0] ptag;                       // Physical tag of the load
    logic [NUM_WAYS-1:0] hit_vec;                 // Per-way match
    logic hit;
    logic hit_way;
    logic victim;                                 // Way chosen by recency
    logic victim_dirty;
    logic cached;                                 // Load may use the arrays
    logic [1:0] fill_qw;                          // Quad-word slot of this beat
    logic fill_we, done_we, lru_we, lru_way;

    assign idx = req_q.vaddr[IDX_HI:IDX_LO];
    assign ptag = req_q.paddr[TAG_HI:TAG_LO];
    assign cached = en_q && req_q.cacheable;

    // One tag compare per way
    for (genvar w = 0; w < NUM_WAYS; w++) begin : g_way
        cpr_way_match #(.TAG_W(TAG_W)) u_match (
            .stored_tag_i(tag_mem[w][idx]),
            .valid_i(valid_q[w][idx]),
            .lookup_tag_i(ptag),
            .hit_o(hit_vec[w])
        );
    end

    assign hit = |hit_vec;
    assign hit_way = hit_vec[1];
    assign victim = lru_q[idx];
    assign victim_dirty = dirty_q[victim][idx];
    assign fill_qw = req_q.vaddr[QW_HI:QW_LO] + beat_q;

    // Aligns and trims a quad-word to the access size
    function automatic logic [QW_W-1:0] sized(input logic [QW_W-1:0] qw,
                                              input logic [2:0] ofs,
                                              input logic [1:0] sz);
        logic [QW_W-1:0] sh;
        sh = qw >> {ofs, 3'h0};
        case (sz)
            2'h0: sized = {56'h0, sh[7:0]};
            2'h1: sized = {48'h0, sh[15:0]};
            2'h2: sized = {32'h0, sh[31:0]};
            default: sized = sh;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sequence next state
    always_comb begin
        state_d = state_q;
        req_d = req_q;
        en_d = en_q;
        way_d = way_q;
        beat_d = beat_q;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        wbpend_d = wbpend_q;
        wb_addr_d = wb_addr_q;
        wb_data_d = wb_data_q;
        rd_cmd_d = rd_cmd_q;
        fill_we = 1'b0;
        done_we = 1'b0;
        lru_we = 1'b0;
        lru_way = way_q;
        case (state_q)
            ST_IDLE: begin
                // Take a new load with the enable seen at that moment
                if (REQ_VALID_I) begin
                    req_d = REQ_I;
                    en_d = CACHE_ENABLE_I;
                    state_d = ST_LOOKUP;
                end
            end
            ST_LOOKUP: begin
                if (!cached) begin
                    // Single-beat read straight from memory
                    rd_cmd_d = '{addr: {req_q.paddr[PA_W-1:QW_LO], 3'h0}, burst: 1'b0};
                    state_d = ST_BYP_REQ;
                end else if (hit) begin
                    // Return sized data and mark the way newest
                    rsp_valid_d = 1'b1;
                    rsp_data_d = sized(data_mem[hit_way][idx][req_q.vaddr[QW_HI:QW_LO]],
                                       req_q.vaddr[2:0], req_q.size);
                    lru_we = 1'b1;
                    lru_way = hit_way;
                    way_d = hit_way;
                    state_d = ST_IDLE;
                end else begin
                    // Miss: wrapping line read from the missed quad-word
                    way_d = victim;
                    beat_d = 2'h0;
                    rd_cmd_d = '{addr: {req_q.paddr[PA_W-1:QW_LO], 3'h0}, burst: 1'b1};
                    if (victim_dirty) begin
                        state_d = ST_SAVE;
                    end else begin
                        state_d = ST_FILL_REQ;
                    end
                end
            end
            ST_SAVE: begin
                // Copy victim tag and data before the refill starts
                wb_addr_d = {tag_mem[way_q][idx], req_q.vaddr[TAG_LO-1:IDX_LO], 5'h0};
                for (int k = 0; k < BEATS; k++) begin
                    wb_data_d[k] = data_mem[way_q][idx][k];
                end
                wbpend_d = 1'b1;
                state_d = ST_FILL_REQ;
            end
            ST_FILL_REQ: begin
                if (MEM_RD_ACK_I) begin
                    state_d = ST_FILL;
                end
            end
            ST_FILL: begin
                if (MEM_RD_VALID_I) begin
                    fill_we = 1'b1;
                    beat_d = beat_q + 2'h1;
                    if (beat_q == 2'h0) begin
                        // Critical beat goes to the core at once
                        rsp_valid_d = 1'b1;
                        rsp_data_d = sized(MEM_RD_DATA_I, req_q.vaddr[2:0], req_q.size);
                    end
                    if (beat_q == LAST_BEAT) begin
                        // Line complete: record tag, newest way
                        done_we = 1'b1;
                        lru_we = 1'b1;
                        state_d = wbpend_q ? ST_WB : ST_IDLE;
                    end
                end
            end
            ST_WB: begin
                // Drain the buffer after the refill
                if (MEM_WR_READY_I) begin
                    beat_d = beat_q + 2'h1;
                    if (beat_q == LAST_BEAT) begin
                        wbpend_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_BYP_REQ: begin
                if (MEM_RD_ACK_I) begin
                    state_d = ST_BYP_WAIT;
                end
            end
            ST_BYP_WAIT: begin
                // Uncached data passes through untouched arrays
                if (MEM_RD_VALID_I) begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d = sized(MEM_RD_DATA_I, req_q.vaddr[2:0], req_q.size);
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Sequence registers
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            en_q <= 1'b0;
            way_q <= 1'b0;
            beat_q <= 2'h0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
            wbpend_q <= 1'b0;
            wb_addr_q <= '0;
            wb_data_q <= '{default: '0};
            rd_cmd_q <= '0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            en_q <= en_d;
            way_q <= way_d;
            beat_q <= beat_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            wbpend_q <= wbpend_d;
            wb_addr_q <= wb_addr_d;
            wb_data_q <= wb_data_d;
            rd_cmd_q <= rd_cmd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag and recency arrays; a store marking dirty wins over a fill clear
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int w = 0; w < NUM_WAYS; w++) begin
                valid_q[w] <= {NUM_SETS{VALID_RST}};
                dirty_q[w] <= {NUM_SETS{DIRTY_RST}};
            end
            lru_q <= {NUM_SETS{LRU_RST}};
        end else begin
            if (done_we) begin
                valid_q[way_q][idx] <= 1'b1;
                dirty_q[way_q][idx] <= 1'b0;
            end
            if (DIRTY_SET_I) begin
                dirty_q[DIRTY_SET_WAY_I][DIRTY_SET_INDEX_I] <= 1'b1;
            end
            if (lru_we) begin
                lru_q[idx] <= !lru_way;
            end
        end
    end

    // Tag and data arrays, no reset
    always_ff @(posedge SYS_CLK_I) begin
        if (fill_we) begin
            data_mem[way_q][idx][fill_qw] <= MEM_RD_DATA_I;
        end
        if (done_we) begin
            tag_mem[way_q][idx] <= ptag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign REQ_READY_O = (state_q == ST_IDLE);
    assign RSP_VALID_O = rsp_valid_q;
    assign RSP_DATA_O = rsp_data_q;
    assign MEM_RD_REQ_O = (state_q == ST_FILL_REQ) || (state_q == ST_BYP_REQ);
    assign MEM_RD_CMD_O = rd_cmd_q;
    assign MEM_WR_VALID_O = (state_q == ST_WB);
    assign MEM_WR_ADDR_O = wb_addr_q;
    assign MEM_WR_DATA_O = wb_data_q[beat_q];
    assign MEM_WR_LAST_O = (state_q == ST_WB) && (beat_q == LAST_BEAT);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence s_dirty_miss;
        state_q == ST_LOOKUP && cached && !hit && victim_dirty;
    endsequence
    sequence s_fill_end;
        state_q == ST_FILL && MEM_RD_VALID_I && beat_q == LAST_BEAT;
    endsequence

    cache_gate_a: assert property (lru_we |-> cached)
        else $error("recency changed on an uncached load");
    hit_tag_a: assert property (state_q == ST_LOOKUP && hit |->
        tag_mem[hit_way][req_q.vaddr[IDX_HI:IDX_LO]] == req_q.paddr[TAG_HI:TAG_LO]
        && valid_q[hit_way][req_q.vaddr[IDX_HI:IDX_LO]])
        else $error("hit without matching valid tag");
    hit_resp_a: assert property (state_q == ST_LOOKUP && cached && hit |=>
        RSP_VALID_O && lru_q[$past(idx)] == !$past(hit_way) && state_q == ST_IDLE)
        else $error("hit not answered or recency not updated");
    clean_miss_a: assert property (state_q == ST_LOOKUP && cached && !hit && !victim_dirty
        |=> state_q == ST_FILL_REQ && !wbpend_q)
        else $error("clean miss took the eviction path");
    dirty_save_a: assert property (s_dirty_miss |=> state_q == ST_SAVE ##1
        (state_q == ST_FILL_REQ && wbpend_q))
        else $error("dirty victim not buffered before refill");
    wrap_start_a: assert property (MEM_RD_REQ_O |->
        MEM_RD_CMD_O.addr[QW_HI:QW_LO] == req_q.vaddr[QW_HI:QW_LO])
        else $error("line read does not start at missed quad-word");
    early_data_a: assert property (state_q == ST_FILL && MEM_RD_VALID_I && beat_q == 2'h0
        |=> RSP_VALID_O && state_q == ST_FILL)
        else $error("critical data not returned on first beat");
    fill_done_a: assert property (s_fill_end |=> valid_q[$past(way_q)][$past(idx)]
        && lru_q[$past(idx)] == !$past(way_q))
        else $error("finished line not valid or not newest");
    wb_after_a: assert property (s_fill_end ##0 wbpend_q |=> MEM_WR_VALID_O
        && MEM_WR_ADDR_O == wb_addr_q)
        else $error("buffer not drained after refill");
    bypass_a: assert property ((state_q == ST_BYP_REQ || state_q == ST_BYP_WAIT)
        |-> !fill_we && !done_we && !lru_we && !MEM_RD_CMD_O.burst)
        else $error("uncached load touched the arrays");

endmodule

`default_nettype wire

// ---- testbench/cpr_mem_model.sv ----
/*
 * Behavioural memory that sits on the read and write ports of the cache read path.
 * Assumes commands arrive as level requests held until acknowledged; inputs move at
 * the falling clock edge so that the design samples settled values.
 */
`default_nettype none

module cpr_mem_model
    import cpr_pkg::*;
(
    // Clock and pace
    input wire logic clk_i,
    input wire logic slow_i,
    // Read port
    input wire logic rd_req_i,
    input wire cpr_rd_cmd_t rd_cmd_i,
    output logic rd_ack_o,
    output logic rd_valid_o,
    output logic [QW_W-1:0] rd_data_o,
    // Write port
    output logic wr_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Memory contents: every quad-word carries its own address
    function automatic logic [QW_W-1:0] qw_of(input logic [PA_W-1:0] a);
        return {3'h5, a, 3'h2, ~a};
    endfunction

    logic [2:0] left_q = 3'h0; // Beats still owed
    logic [1:0] k_q = 2'h0; // Beat number within the burst
    logic tick_q = 1'b0; // Toggles each cycle, paces the slow mode
    cpr_rd_cmd_t cmd_q = '0; // Accepted command

    ////////////////////////////////////////////////////////////////////////////
    // Answers; idle data shows the inverse of the last value, so a stale beat returns every second idle cycle
    always @(negedge clk_i) begin
        tick_q = ~tick_q;
        rd_ack_o = 1'b0;
        rd_valid_o = 1'b0;
        rd_data_o = ~rd_data_o;
        wr_ready_o = !slow_i || tick_q;
        if (left_q != 3'h0) begin
            // Beats walk the line from the missed quad-word and wrap
            if (!slow_i || tick_q) begin
                rd_valid_o = 1'b1;
                rd_data_o = qw_of({cmd_q.addr[PA_W-1:5], cmd_q.addr[4:3] + k_q, 3'h0});
                k_q = k_q + 2'h1;
                left_q = left_q - 3'h1;
            end
        end else if (rd_req_i && (!slow_i || tick_q)) begin
            // Take the command, burst of four or one beat
            rd_ack_o = 1'b1;
            cmd_q = rd_cmd_i;
            k_q = 2'h0;
            left_q = rd_cmd_i.burst ? 3'h4 : 3'h1;
        end
    end

endmodule

`default_nettype wire

// ---- testbench/cpr_read_path_test.sv ----
/*
 * Self-checking bench of the cache read path: a table of loads, then eviction,
 * slow memory and reset by hand.
 * Assumes identity translation below bit 29 and the memory model beside it.
 */
`default_nettype none

module cpr_read_path_test
    import cpr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [PA_W-1:0] pa; // Physical address, virtual low bits equal
        logic [1:0] size; // Access width code
        logic cach; // Cacheable region
        logic en; // Cache enabled
        logic [1:0] kind; // 0 hit, 1 line fill, 2 bypass
    } cpr_row_t;

    // Design and model signals
    logic SYS_CLK_I = 1'b0, RSTN_I = 1'b0, REQ_VALID_I = 1'b0, CACHE_ENABLE_I = 1'b0;
    logic DIRTY_SET_I = 1'b0, DIRTY_SET_WAY_I = 1'b0, slow = 1'b0;
    logic [IDX_W-1:0] DIRTY_SET_INDEX_I = '0;
    cpr_req_t REQ_I = '0;
    logic REQ_READY_O, RSP_VALID_O, MEM_RD_REQ_O, MEM_RD_ACK_I, MEM_RD_VALID_I;
    logic MEM_WR_VALID_O, MEM_WR_LAST_O, MEM_WR_READY_I;
    logic [QW_W-1:0] RSP_DATA_O, MEM_RD_DATA_I, MEM_WR_DATA_O;
    logic [PA_W-1:0] MEM_WR_ADDR_O;
    cpr_rd_cmd_t MEM_RD_CMD_O, last_cmd;
    // Bookkeeping
    int bad_count = 0, n_tests = 0, cycles = 0, rd_beats = 0, n_burst = 0, n_single = 0;
    logic [QW_W+PA_W:0] wr_q[$]; // Write beats: last, address, data
    int wr_at[$]; // Read beats seen when each write beat went out
    localparam logic [PA_W-1:0] LA = 29'h0010028, LB = 29'h001202f, LC = 29'h0014030;
    cpr_row_t rows[10] = '{'{LA, 2'h3, 1'b1, 1'b1, 2'h1}, '{LA, 2'h3, 1'b1, 1'b1, 2'h0},
        '{29'h001002a, 2'h1, 1'b1, 1'b1, 2'h0}, '{29'h001002c, 2'h2, 1'b1, 1'b1, 2'h0},
        '{LA, 2'h3, 1'b1, 1'b0, 2'h2}, '{29'h0010029, 2'h0, 1'b0, 1'b1, 2'h2},
        '{LA, 2'h2, 1'b1, 1'b1, 2'h0}, '{LB, 2'h0, 1'b1, 1'b1, 2'h1},
        '{LA, 2'h3, 1'b1, 1'b1, 2'h0}, '{LB, 2'h0, 1'b1, 1'b1, 2'h0}};

    always #2.5 SYS_CLK_I = ~SYS_CLK_I;

    cpr_read_path dut (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .REQ_VALID_I(REQ_VALID_I),
        .REQ_READY_O(REQ_READY_O), .REQ_I(REQ_I), .CACHE_ENABLE_I(CACHE_ENABLE_I),
        .RSP_VALID_O(RSP_VALID_O), .RSP_DATA_O(RSP_DATA_O), .DIRTY_SET_I(DIRTY_SET_I),
        .DIRTY_SET_INDEX_I(DIRTY_SET_INDEX_I), .DIRTY_SET_WAY_I(DIRTY_SET_WAY_I),
        .MEM_RD_REQ_O(MEM_RD_REQ_O), .MEM_RD_CMD_O(MEM_RD_CMD_O), .MEM_RD_ACK_I(MEM_RD_ACK_I),
        .MEM_RD_VALID_I(MEM_RD_VALID_I), .MEM_RD_DATA_I(MEM_RD_DATA_I),
        .MEM_WR_VALID_O(MEM_WR_VALID_O), .MEM_WR_ADDR_O(MEM_WR_ADDR_O),
        .MEM_WR_DATA_O(MEM_WR_DATA_O), .MEM_WR_LAST_O(MEM_WR_LAST_O),
        .MEM_WR_READY_I(MEM_WR_READY_I));

    cpr_mem_model mem (.clk_i(SYS_CLK_I), .slow_i(slow), .rd_req_i(MEM_RD_REQ_O),
        .rd_cmd_i(MEM_RD_CMD_O), .rd_ack_o(MEM_RD_ACK_I), .rd_valid_o(MEM_RD_VALID_I),
        .rd_data_o(MEM_RD_DATA_I), .wr_ready_o(MEM_WR_READY_I));

    ////////////////////////////////////////////////////////////////////////////
    // Closing report, the one place the run ends
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [QW_W+PA_W:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Bus monitor and hang guard, sampling pre-edge values
    always @(posedge SYS_CLK_I) begin
        cycles++;
        if (MEM_RD_VALID_I) rd_beats++;
        if (MEM_RD_REQ_O && MEM_RD_ACK_I) begin
            last_cmd = MEM_RD_CMD_O;
            if (MEM_RD_CMD_O.burst) n_burst++;
            else n_single++;
        end
        if (MEM_WR_VALID_O && MEM_WR_READY_I) begin
            wr_q.push_back({MEM_WR_LAST_O, MEM_WR_ADDR_O, MEM_WR_DATA_O});
            wr_at.push_back(rd_beats);
        end
        // Hang guard last, so nothing runs after the closing report
        if (cycles > 5000) begin
            bad_count++;
            stop_test();
        end
    end

    // One load: hold the request until taken, then time and judge the answer
    task automatic load(input cpr_row_t r);
        int lat, nb, ns, bt;
        logic [QW_W-1:0] exp;
        exp = mem.qw_of({r.pa[PA_W-1:3], 3'h0}) >> (r.pa[2:0] * 8);
        if (r.size != 2'h3) exp &= (64'h1 << (8 << r.size)) - 64'h1;
        REQ_I = '{vaddr: {3'h7, r.pa}, paddr: r.pa, size: r.size, cacheable: r.cach};
        CACHE_ENABLE_I = r.en;
        REQ_VALID_I = 1'b1;
        lat = 0;
        while (!REQ_READY_O && lat < 200) begin
            @(negedge SYS_CLK_I);
            lat++;
        end
        // Count from here, once the previous line has fully arrived
        nb = n_burst;
        ns = n_single;
        bt = rd_beats;
        @(negedge SYS_CLK_I);
        REQ_VALID_I = 1'b0;
        lat = 1;
        while (!RSP_VALID_O && lat < 200) begin
            @(negedge SYS_CLK_I);
            lat++;
        end
        check("load data", RSP_DATA_O, exp);
        check("burst reads", n_burst - nb, (r.kind == 2'h1));
        check("single reads", n_single - ns, (r.kind == 2'h2));
        if (r.kind == 2'h0) check("hit latency", lat, 2);
        if (r.kind == 2'h1) check("beats at answer", rd_beats - bt, 1);
        if (r.kind != 2'h0) check("read address", last_cmd.addr, {r.pa[PA_W-1:3], 3'h0});
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 200 && !REQ_READY_O; i++) @(negedge SYS_CLK_I);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(negedge SYS_CLK_I);
        RSTN_I = 1'b1;
        // Table of ordinary loads
        foreach (rows[i]) load(rows[i]);
        // Dirty victim: way 0 of set 1 holds the line at LA, evicted by LC
        wait_idle();
        DIRTY_SET_I = 1'b1;
        DIRTY_SET_INDEX_I = 8'h01;
        @(negedge SYS_CLK_I);
        DIRTY_SET_I = 1'b0;
        slow <= 1'b1;
        load('{LC, 2'h3, 1'b1, 1'b1, 2'h1});
        wait_idle();
        check("write beats", wr_q.size(), 4);
        for (int k = 0; k < 4 && k < wr_q.size(); k++) begin
            check("write beat", wr_q[k], {k == 3, 29'h0010020, mem.qw_of(29'h0010020 + k * 8)});
            check("refill done first", wr_at[k], rd_beats);
        end
        // Clean victim next: no write-back
        load('{LA, 2'h1, 1'b1, 1'b1, 2'h1});
        wait_idle();
        check("clean victim writes", wr_q.size(), 4);
        slow <= 1'b0;
        // Reset in mid-run clears the valid flags
        RSTN_I = 1'b0;
        #1;
        check("reset outputs", {REQ_READY_O, RSP_VALID_O, MEM_RD_REQ_O, MEM_WR_VALID_O}, 4'h8);
        repeat (3) @(negedge SYS_CLK_I);
        RSTN_I = 1'b1;
        load('{LA, 2'h3, 1'b1, 1'b1, 2'h1});
        load('{LA, 2'h3, 1'b1, 1'b1, 2'h0});
        stop_test();
    end

endmodule

`default_nettype wire
